/* File: hw/dasr_readout.sv */
// Serial conversion and readout logic of a dual simultaneous-sampling converter
//
// Contract
// RQ1 - Select falling holds, samples, starts, enables outputs
// RQ2 - Conversion needs sixteen serial clocks while selected
// RQ3 - After sixteen falling edges, track on next rise
// RQ4 - Select rising aborts and tri-states outputs immediately
// RQ5 - Next sixteen clocks: second result on first output
// RQ6 - Next sixteen clocks: first result on second output
// RQ7 - Tri-state at 32nd falling edge or select rise
// RQ8 - Each frame outputs the previous conversion result
// RQ9 - Zero at select fall, second zero first edge
// RQ10 - Fourteen result bits follow; last launched fifteenth edge
// RQ11 - Slow host may sample on rising edges
// RQ12 - Host waits idle gap before next select
// RQ13 - Result shifted most significant bit first
`timescale 1ns/1ps
module dasr_readout import dasr_pkg::*; (
  input  wire logic             ref_clk,              // Core clock, 250 MHz
  input  wire logic             arst_n,               // Asynchronous reset, active low
  input  wire logic             serial_clk,           // Serial and conversion clock from host
  input  wire logic             cs_n,                 // Chip select from host, active low
  input  wire logic [RES_W-1:0] sample_a,             // Digitised input of converter A
  input  wire logic [RES_W-1:0] sample_b,             // Digitised input of converter B
  output logic                  serial_out_first,     // Data out, converter A line
  output logic                  serial_out_first_oe,  // Drive enable of first line
  output logic                  serial_out_second,    // Data out, converter B line
  output logic                  serial_out_second_oe, // Drive enable of second line
  output logic                  sample_hold           // High while track-and-hold is in hold
);

  dasr_ref_t  ref_q,  ref_d;                          // Ref domain state
  dasr_fall_t fall_q, fall_d;                         // Falling-edge frame state
  dasr_rise_t rise_q, rise_d;                         // Rising-edge frame state
  dasr_tog_t  tog_q,  tog_d;                          // Completion toggle
  logic       link_rst_n;                             // Frame reset: select high or global reset
  logic [1:0] sync_q;                                 // Synced {toggle, select}
  logic       frame_start;                            // One-cycle pulse at select fall
  logic       out_live;                               // Frame has not yet ended
  logic       conv_done;                              // A finished conversion is waiting, this cycle included

  // Select high ends the frame at once, without waiting for a serial edge
  assign link_rst_n = arst_n & ~cs_n; // RQ4

  // Bit of the 32-bit frame presented after cnt falling edges
  function automatic logic frame_bit(input logic [CNT_W-1:0] cnt,
                                     input logic [RES_W-1:0] own,
                                     input logic [RES_W-1:0] other);
    logic [CNT_W-1:0] idx;
    idx = '0;
    frame_bit = 1'b0;
    if (cnt < LEAD_ZEROS) begin
      frame_bit = 1'b0; // RQ9
    end else if (cnt < WORD_EDGES) begin
      idx = WORD_TOP - cnt;
      frame_bit = own[idx[3:0]]; // RQ10 RQ13
    end else if ((cnt >= WORD_EDGES + LEAD_ZEROS) && (cnt < FRAME_END)) begin
      idx = FRAME_TOP - cnt;
      frame_bit = other[idx[3:0]]; // RQ5 RQ6
    end else begin
      frame_bit = 1'b0;
    end
  endfunction : frame_bit

  // Bring select and the completion toggle into the ref domain
  dasr_sync #(
    .W       (2),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .d       ({tog_q.tog, cs_n}),
    .q       (sync_q)
  );

  assign frame_start = ref_q.cs_prev & ~sync_q[0];

  // A toggle that lands in the same cycle as a new select fall still counts;
  // otherwise that finished conversion would be dropped and the old result repeated
  assign conv_done   = ref_q.conv_ok | (sync_q[1] != ref_q.tog_seen); // RQ8

  // Ref domain: sample at frame start, promote a finished conversion to result
  always_comb begin
    ref_d         = ref_q;
    ref_d.cs_prev = sync_q[0];
    if (sync_q[1] != ref_q.tog_seen) begin
      // Sixteen edges passed, so the conversion in flight is complete
      ref_d.tog_seen = sync_q[1];
      ref_d.conv_ok  = 1'b1; // RQ2
    end
    if (frame_start) begin
      // Result changes only here, so it is static for the whole frame read
      if (conv_done) begin
        ref_d.res_a = ref_q.conv_a; // RQ8
        ref_d.res_b = ref_q.conv_b; // RQ8
      end
      ref_d.conv_a  = sample_a; // RQ1
      ref_d.conv_b  = sample_b; // RQ1
      ref_d.conv_ok = 1'b0;
    end
  end

  // Ref domain registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_q <= '{cs_prev: 1'b1, tog_seen: 1'b0, conv_ok: 1'b0,
                 conv_a: RES_RST, conv_b: RES_RST, res_a: RES_RST, res_b: RES_RST};
    end else begin
      ref_q <= ref_d;
    end
  end

  // Count falling edges, stopping once the frame is over
  always_comb begin
    fall_d = fall_q;
    if (fall_q.cnt < FRAME_END) begin
      fall_d.cnt = fall_q.cnt + 6'h01;
    end
  end

  // Counter is held clear while select is high
  always_ff @(negedge serial_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      fall_q <= '0; // RQ4
    end else begin
      fall_q <= fall_d;
    end
  end

  // Completion toggle flips on the sixteenth falling edge of a frame
  always_comb begin
    tog_d = tog_q;
    if (fall_q.cnt == LAST_EDGE && !cs_n) begin
      tog_d.tog = ~tog_q.tog; // RQ2
    end
  end

  // Toggle must survive select high, so only the global reset clears it
  always_ff @(negedge serial_clk or negedge arst_n) begin
    if (!arst_n) begin
      tog_q <= '0;
    end else begin
      tog_q <= tog_d;
    end
  end

  // Return to track on the rising edge after sixteen falling edges
  always_comb begin
    rise_d = rise_q;
    if (fall_q.cnt >= WORD_EDGES) begin
      rise_d.track = 1'b1; // RQ3
    end
  end

  // Rising-edge register, cleared by select high
  always_ff @(posedge serial_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rise_q <= '0;
    end else begin
      rise_q <= rise_d;
    end
  end

  // Pins must react to select with no serial edge, so they decode flops directly
  assign out_live             = link_rst_n & (fall_q.cnt < FRAME_END); // RQ7
  assign serial_out_first_oe  = out_live; // RQ1
  assign serial_out_second_oe = out_live; // RQ1
  assign serial_out_first     = out_live & frame_bit(fall_q.cnt, ref_q.res_a, ref_q.res_b);
  assign serial_out_second    = out_live & frame_bit(fall_q.cnt, ref_q.res_b, ref_q.res_a);
  assign sample_hold          = link_rst_n & ~rise_q.track; // RQ1 RQ3

  // Checks on the serial side and on the ref domain result registers
  a_idle_tristate: assert property (@(posedge ref_clk) disable iff (!arst_n) // RQ4
    cs_n |-> !serial_out_first_oe && !serial_out_second_oe)
    else $error("output enabled while select is high");

  // Looked at on the rise after the last fall, while select is still low
  a_frame_end_off: assert property (@(posedge serial_clk) disable iff (!link_rst_n) // RQ7
    (fall_q.cnt == FRAME_END) |-> !serial_out_first_oe && !serial_out_second_oe)
    else $error("output still driven after frame end");

  a_lead_zeros: assert property (@(negedge serial_clk) disable iff (!link_rst_n) // RQ9
    (fall_q.cnt < LEAD_ZEROS) |-> serial_out_first_oe && !serial_out_first && !serial_out_second)
    else $error("leading zero missing");

  a_msb_first: assert property (@(negedge serial_clk) disable iff (!link_rst_n) // RQ13
    (fall_q.cnt == LEAD_ZEROS) |-> serial_out_first == ref_q.res_a[RES_W-1])
    else $error("first result bit is not the msb");

  a_lsb_at_15: assert property (@(negedge serial_clk) disable iff (!link_rst_n) // RQ10
    (fall_q.cnt == LAST_EDGE) |-> serial_out_first == ref_q.res_a[0] && serial_out_second == ref_q.res_b[0])
    else $error("last result bit misplaced");

  a_swap_first: assert property (@(negedge serial_clk) disable iff (!link_rst_n) // RQ5
    (fall_q.cnt == WORD_EDGES + LEAD_ZEROS) |-> serial_out_first == ref_q.res_b[RES_W-1])
    else $error("second word on first line is not converter B");

  a_swap_second: assert property (@(negedge serial_clk) disable iff (!link_rst_n) // RQ6
    (fall_q.cnt == FRAME_TOP) |-> serial_out_second == ref_q.res_a[0])
    else $error("second word on second line is not converter A");

  // Half a serial cycle after the rise that follows the sixteenth fall, track must show
  a_track_return: assert property (@(negedge serial_clk) disable iff (!link_rst_n) // RQ3
    (fall_q.cnt >= WORD_EDGES) |-> !sample_hold)
    else $error("track-and-hold did not return to track");

  a_hold_start: assert property (@(negedge serial_clk) disable iff (!link_rst_n) // RQ1
    (fall_q.cnt < WORD_EDGES) |-> sample_hold && serial_out_second_oe)
    else $error("not holding early in frame");

  a_conv_done: assert property (@(negedge serial_clk) disable iff (!link_rst_n) // RQ2
    (fall_q.cnt == LAST_EDGE) |=> tog_q.tog != $past(tog_q.tog))
    else $error("conversion completion not signalled");

  a_result_pipe: assert property (@(posedge ref_clk) disable iff (!arst_n) // RQ8
    (frame_start && conv_done) |=> ref_q.res_a == $past(ref_q.conv_a) && ref_q.res_b == $past(ref_q.conv_b))
    else $error("previous conversion not promoted");

  // An aborted frame must leave the delivered result untouched
  a_abort_keep: assert property (@(posedge ref_clk) disable iff (!arst_n) // RQ4
    (frame_start && !conv_done) |=> ref_q.res_a == $past(ref_q.res_a) && ref_q.res_b == $past(ref_q.res_b))
    else $error("aborted conversion changed the result");

endmodule : dasr_readout

/* File: hw/dasr_pkg.sv */
// Shared constants and state types for the dual converter serial readout
package dasr_pkg;

  localparam int unsigned RES_W      = 14;            // Result width of each converter
  localparam int unsigned CNT_W      = 6;             // Falling-edge counter width
  localparam logic [5:0]  LEAD_ZEROS = 6'h02;         // Leading zero bits of each word
  localparam logic [5:0]  WORD_EDGES = 6'h10;         // Falling edges in one 16-bit word
  localparam logic [5:0]  LAST_EDGE  = 6'h0f;         // Edge that launches the last bit of a word
  localparam logic [5:0]  FRAME_END  = 6'h20;         // Edge that ends a 32-clock frame
  localparam logic [5:0]  WORD_TOP   = 6'h0f;         // Index base of the first word (16 - 1)
  localparam logic [5:0]  FRAME_TOP  = 6'h1f;         // Index base of the second word (32 - 1)
  localparam logic [13:0] RES_RST    = 14'h0000;      // Result value after reset
  localparam logic [1:0]  SYNC_RST   = 2'h1;          // Synchroniser reset: select high, toggle low

  // Ref clock domain state
  typedef struct packed {
    logic             cs_prev;   // Synced select seen last cycle
    logic             tog_seen;  // Last conversion toggle consumed
    logic             conv_ok;   // Conversion in flight has completed
    logic [RES_W-1:0] conv_a;    // Sample held for converter A
    logic [RES_W-1:0] conv_b;    // Sample held for converter B
    logic [RES_W-1:0] res_a;     // Previous result of converter A
    logic [RES_W-1:0] res_b;     // Previous result of converter B
  } dasr_ref_t;

  // Serial clock falling-edge state, cleared by select high
  typedef struct packed {
    logic [CNT_W-1:0] cnt;       // Falling edges seen in this frame
  } dasr_fall_t;

  // Serial clock rising-edge state, cleared by select high
  typedef struct packed {
    logic             track;     // Track-and-hold returned to track
  } dasr_rise_t;

  // Serial clock state that survives between frames
  typedef struct packed {
    logic             tog;       // Flips once per completed conversion
  } dasr_tog_t;

endpackage : dasr_pkg

/* File: hw/dasr_sync.sv */
// Two flip-flop synchroniser for levels entering the ref clock domain
`timescale 1ns/1ps
module dasr_sync #(
  parameter int unsigned W       = 2,       // Number of bits
  parameter logic [1:0]  RST_VAL = 2'h0     // Value held under reset
) (
  input  wire logic         ref_clk,        // Destination clock
  input  wire logic         arst_n,         // Asynchronous reset, active low
  input  wire logic [W-1:0] d,              // Level from another domain
  output logic      [W-1:0] q               // Synchronised level
);

  logic [W-1:0] meta_q;                     // First stage, read only by the second

  // Two stages; the first never feeds any logic but the second
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RST_VAL[W-1:0];
      q      <= RST_VAL[W-1:0];
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : dasr_sync

/* File: testbench/dasr_host.sv */
// Host serial port model that frames and reads the converter readout
`timescale 1ns/1ps
module dasr_host (
  output logic      cs_n,       // Select to device, active low
  output logic      serial_clk, // Serial clock, idles high outside frames
  input  wire logic d_a,        // First data line
  input  wire logic oe_a,       // First line drive enable
  input  wire logic d_b,        // Second data line
  input  wire logic oe_b,       // Second line drive enable
  input  wire logic hold        // Track-and-hold state
);
  logic        idle_q = 1'b0;   // Changing level read off a released line
  logic [31:0] word_a;          // First line bits, earliest at the top
  logic [31:0] word_b;          // Second line bits, earliest at the top
  logic [15:0] word_r;          // First line bits on rising edges, select fall at the top
  logic [4:0]  flags;           // oe/hold at start, hold late, oe at end, oe off
  // A released line must not look like it kept its last value
  wire logic   line_a = oe_a ? d_a : idle_q;
  wire logic   line_b = oe_b ? d_b : idle_q;

  initial begin
    cs_n = 1'b1;
    serial_clk = 1'b1;
  end

  // Pattern for released lines changes every serial cycle
  always @(negedge serial_clk) idle_q <= ~idle_q;

  // One frame of n serial clocks, period 160 ns
  task automatic frame(input int n);
    word_a = '0;
    word_b = '0;
    word_r = '0;
    flags = '0;
    #33 cs_n = 1'b0;
    #1 flags[4] = oe_a & oe_b;
    flags[3] = hold;
    word_r[15] = line_a;
    for (int i = 0; i < n; i++) begin
      // Falling-edge capture, taken just before the edge
      #79 word_a[31-i] = line_a;
      word_b[31-i] = line_b;
      // Sampled after the rise that follows the sixteenth fall
      if (i == 16) flags[2] = hold;
      #1 serial_clk = 1'b0;
      #80 serial_clk = 1'b1;
      // Slow host capture: rises 1 to 15 give the second zero through the lsb
      if (i < 15) word_r[14-i] = line_a;
    end
    #79 flags[1] = oe_a | oe_b;
    cs_n = 1'b1;
    #1 flags[0] = oe_a | oe_b;
    // Gap also lets the core see the completed conversion
    #200;
  endtask : frame
endmodule : dasr_host

/* File: testbench/testbench.sv */
// Self-checking bench for the dual converter serial readout
`timescale 1ns/1ps
module testbench import dasr_pkg::*; ;
  logic             ref_clk = 1'b0;   // Core clock, 4 ns
  logic             arst_n = 1'b0;    // Reset, active low
  logic [RES_W-1:0] sample_a = '0;    // Converter A input
  logic [RES_W-1:0] sample_b = '0;    // Converter B input
  wire logic        cs_n;             // Select from host
  wire logic        serial_clk;       // Serial clock from host
  wire logic        d_a;              // First data line
  wire logic        oe_a;             // First line enable
  wire logic        d_b;              // Second data line
  wire logic        oe_b;             // Second line enable
  wire logic        hold;             // Track-and-hold state
  int               fails = 0;        // Mismatches seen
  int               num_checks = 0;   // Comparisons made
  int               cycles = 0;       // Clock cycles run

  dasr_readout dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .serial_clk(serial_clk), .cs_n(cs_n),
    .sample_a(sample_a), .sample_b(sample_b), .serial_out_first(d_a), .serial_out_first_oe(oe_a),
    .serial_out_second(d_b), .serial_out_second_oe(oe_b), .sample_hold(hold));
  dasr_host host_u (.cs_n(cs_n), .serial_clk(serial_clk), .d_a(d_a), .oe_a(oe_a), .d_b(d_b),
    .oe_b(oe_b), .hold(hold));

  // Core clock
  always #2 ref_clk = ~ref_clk;

  // Cut a hang short; the whole run needs about 5000 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 15000) begin
      fails++;
      wrap_up();
    end
  end

  // Expected 32-bit line frame: two zeros before each word
  function automatic logic [31:0] w(input logic [13:0] a, input logic [13:0] b);
    return {2'b00, a, 2'b00, b};
  endfunction : w

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t ns: expected %h got %h", $time, exp, got);
    end
  endtask : chk

  // Inputs change just after a core clock edge
  task automatic put(input logic [13:0] a, input logic [13:0] b);
    @(posedge ref_clk) #1 sample_a = a;
    sample_b = b;
  endtask : put

  // First frame after reset carries the zero result
  task automatic t_first;
    put(14'h2a5c, 14'h1337);
    host_u.frame(32);
    chk(32'h0, host_u.word_a);
    chk(32'h0, host_u.word_b);
    chk(32'h18, {27'h0, host_u.flags});
    $display("test first_frame done");
  endtask : t_first

  // Full frame returns both words of the previous conversion
  task automatic t_pipe;
    put(14'h3fff, 14'h0001);
    host_u.frame(32);
    chk(w(14'h2a5c, 14'h1337), host_u.word_a);
    chk(w(14'h1337, 14'h2a5c), host_u.word_b);
    chk(32'h2a5c, {16'h0, host_u.word_r});
    chk(32'h18, {27'h0, host_u.flags});
    $display("test pipeline done");
  endtask : t_pipe

  // Aborted conversion keeps the old result; short frames still work
  task automatic t_abort;
    put(14'h0aaa, 14'h0555);
    host_u.frame(8);
    chk(32'h1a, {27'h0, host_u.flags});
    put(14'h2001, 14'h1ffe);
    host_u.frame(16);
    chk({16'h3fff, 16'h0}, {host_u.word_a[31:16], 16'h0});
    chk({16'h0001, 16'h0}, {host_u.word_b[31:16], 16'h0});
    host_u.frame(16);
    chk({16'h2001, 16'h0}, {host_u.word_a[31:16], 16'h0});
    chk({16'h1ffe, 16'h0}, {host_u.word_b[31:16], 16'h0});
    chk(32'h2001, {16'h0, host_u.word_r});
    $display("test abort done");
  endtask : t_abort

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // Reset for 8 cycles, then the scenarios
  initial begin
    repeat (8) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    t_first();
    t_pipe();
    t_abort();
    wrap_up();
  end
endmodule : testbench
